// file: design/clg_regs.svh
/*
 Register offsets, field positions, reset values and divisor counts
 of the clock generation unit. Included by bare name by the design files.
*/
`ifndef CLG_REGS_SVH
`define CLG_REGS_SVH

// Special function register address of the clock control register
`define CLG_CLOCK_CONTROL_ADDR 8'hF9

// Field positions inside the clock control register
`define CLG_PRESCALE_LSB 0
`define CLG_PRESCALE_MSB 2
`define CLG_DBG_ENABLE_BIT 4

// Reset value: undivided core clock, debug comparators on
`define CLG_CLOCK_CONTROL_RESET 8'h10
`define CLG_PRESCALE_RESET 3'h0
`define CLG_DBG_ENABLE_RESET 1'b1

// Divisor terminal counts (divisor minus one), one per select code
`define CLG_LIMIT_SEL0 11'h000
`define CLG_LIMIT_SEL1 11'h001
`define CLG_LIMIT_SEL2 11'h003
`define CLG_LIMIT_SEL3 11'h007
`define CLG_LIMIT_SEL4 11'h00F
`define CLG_LIMIT_SEL5 11'h01F
`define CLG_LIMIT_SEL6 11'h3FF
`define CLG_LIMIT_SEL7 11'h7FF

`endif

// file: design/clg_pkg.sv
/*
 Types shared by the clock generation unit: operating modes and the
 state records of the divider and of the top level.
 Assumes clg_regs.svh for the numeric constants.
*/
package clg_pkg;

    typedef enum logic [1:0] {
        CLG_MODE_RUN,
        CLG_MODE_IDLE,
        CLG_MODE_POWERDOWN
    } clg_mode_t;

    typedef struct packed {
        logic [10:0] count;
        logic tick;
    } clg_div_state_t;

    typedef struct packed {
        logic [2:0] prescale;
        logic dbg_enable;
        logic [7:0] rdata;
        logic [2:0] jtag_sync;
        logic [1:0] sync_fill;
        logic exit_pulse;
        logic periph_run;
        clg_mode_t mode;
    } clg_top_state_t;

endpackage

// file: design/clg_divider.sv
/*
 Core clock divider of the clock generation unit. Produces a one-cycle
 enable every divisor oscillator cycles; the enable drives a clock gate
 downstream, so the derived clock never has a shortened phase.
 Assumes run_i and restart_i come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "clg_regs.svh"

module clg_divider
    import clg_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [2:0] select_i,
    output logic tick_o
);

    clg_div_state_t state_reg;
    clg_div_state_t state_next;

    // Divisors 1, 2, 4, 8, 16, 32, 1024 and 2048
    function automatic logic [10:0] limit_of(input logic [2:0] sel);
        case (sel)
            3'h0: limit_of = `CLG_LIMIT_SEL0;
            3'h1: limit_of = `CLG_LIMIT_SEL1;
            3'h2: limit_of = `CLG_LIMIT_SEL2;
            3'h3: limit_of = `CLG_LIMIT_SEL3;
            3'h4: limit_of = `CLG_LIMIT_SEL4;
            3'h5: limit_of = `CLG_LIMIT_SEL5;
            3'h6: limit_of = `CLG_LIMIT_SEL6;
            default: limit_of = `CLG_LIMIT_SEL7;
        endcase
    endfunction

    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (restart_i || !run_i) begin
            state_next.count = 11'h000;
        end else if (state_reg.count >= limit_of(select_i)) begin
            state_next.count = 11'h000;
            state_next.tick = 1'b1;
        end else begin
            state_next.count = state_reg.count + 11'h001;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_o = state_reg.tick;

endmodule

// file: design/clg_clock_gen.sv
/*
 Clock generation unit: clock control register on the special function
 register port, core clock enable with prescaler, peripheral clock run
 enable, debug comparator enable and low-power exit on debug reset.
 Assumes clk_i is the oscillator input, the power control bits come from
 logic on clk_i, and the debug reset command toggles on the test clock.
*/
// Notes on behaviour
// - All clocks except the test clock derive from the oscillator input.
// - Reset leaves core clock undivided.
// - Prescale field picks one of eight divisors.
// - Prescale write takes effect at once.
// - Powerdown or idle stops the core clock.
// - Core clock feeds core and watchdog.
// - Peripheral clock is always undivided.
// - Peripherals divide peripheral clock themselves.
// - Peripheral clock stops only in powerdown.
// - Test port runs on external test clock.
// - Core-dependent debug unavailable while core halted.
// - Debug reset exits idle or powerdown.
// - Enable bit switches breakpoint comparators.
// - Enable bit set by reset, clearable.
`timescale 1ns/10ps
`include "clg_regs.svh"

module clg_clock_gen
    import clg_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic powerdown_bit_i,
    input wire logic idle_bit_i,
    input wire logic jtag_reset_toggle_i,
    output logic [7:0] sfr_rdata_o,
    output logic core_clk_en_o,
    output logic watchdog_clk_en_o,
    output logic peripheral_clk_en_o,
    output logic debug_comparator_enable_o,
    output logic debug_core_ready_o,
    output logic low_power_exit_o
);

    clg_top_state_t state_reg;
    clg_top_state_t state_next;
    logic hit;
    logic write_hit;
    logic core_run;
    logic core_tick;

    function automatic logic [7:0] pack_control(input logic [2:0] pre, input logic dbg);
        logic [7:0] v;
        v = 8'h00;
        v[`CLG_PRESCALE_MSB:`CLG_PRESCALE_LSB] = pre;
        v[`CLG_DBG_ENABLE_BIT] = dbg;
        pack_control = v;
    endfunction

    assign hit = (sfr_addr_i == `CLG_CLOCK_CONTROL_ADDR);
    assign write_hit = sfr_wr_i && hit;
    // halt core in idle or powerdown
    assign core_run = !powerdown_bit_i && !idle_bit_i;

    // divider runs straight off the oscillator
    clg_divider u_divider (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i(core_run),
        .restart_i(write_hit),
        .select_i(write_hit ? sfr_wdata_i[`CLG_PRESCALE_MSB:`CLG_PRESCALE_LSB]
                            : state_reg.prescale),
        .tick_o(core_tick)
    );

    always_comb begin
        state_next = state_reg;
        state_next.exit_pulse = 1'b0;
        state_next.rdata = 8'h00;
        // new prescale and enable stored on write
        if (write_hit) begin
            state_next.prescale = sfr_wdata_i[`CLG_PRESCALE_MSB:`CLG_PRESCALE_LSB];
            state_next.dbg_enable = sfr_wdata_i[`CLG_DBG_ENABLE_BIT];
        end
        // Unmapped reads return zero
        if (sfr_rd_i && hit) begin
            state_next.rdata = pack_control(state_reg.prescale, state_reg.dbg_enable);
        end
        // peripheral clock stops only in powerdown
        state_next.periph_run = !powerdown_bit_i;
        if (powerdown_bit_i) begin
            state_next.mode = CLG_MODE_POWERDOWN;
        end else if (idle_bit_i) begin
            state_next.mode = CLG_MODE_IDLE;
        end else begin
            state_next.mode = CLG_MODE_RUN;
        end
        // command crosses from the test clock domain
        state_next.jtag_sync = {state_reg.jtag_sync[1:0], jtag_reset_toggle_i};
        // Chain starts from zero, not from the pin level: no edges until it is refilled
        // Limitation: a toggle before the first clock edge after reset is lost
        if (state_reg.sync_fill != 2'h3) begin
            state_next.sync_fill = state_reg.sync_fill + 2'h1;
        end
        case (state_reg.mode)
            CLG_MODE_IDLE, CLG_MODE_POWERDOWN: begin
                state_next.exit_pulse = (state_reg.sync_fill == 2'h3)
                    && (state_reg.jtag_sync[2] ^ state_reg.jtag_sync[1]);
            end
            default: begin
                state_next.exit_pulse = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg.prescale <= `CLG_PRESCALE_RESET;
            state_reg.dbg_enable <= `CLG_DBG_ENABLE_RESET;
            state_reg.rdata <= 8'h00;
            state_reg.jtag_sync <= 3'h0;
            state_reg.sync_fill <= 2'h0;
            state_reg.exit_pulse <= 1'b0;
            state_reg.periph_run <= 1'b1;
            state_reg.mode <= CLG_MODE_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sfr_rdata_o = state_reg.rdata;
    // core and watchdog share one enable
    assign core_clk_en_o = core_tick;
    assign watchdog_clk_en_o = core_tick;
    // each peripheral applies its own divider
    assign peripheral_clk_en_o = state_reg.periph_run;
    assign debug_comparator_enable_o = state_reg.dbg_enable;
    // core debug only while core clock runs
    assign debug_core_ready_o = (state_reg.mode == CLG_MODE_RUN);
    assign low_power_exit_o = state_reg.exit_pulse;

endmodule

// file: design/dummy_none.sv
/*
 Deliberately holds no module.
*/

// file: testbench/clg_clock_gen_properties.sv
/* Port checker for clg_clock_gen.
 Sees only the top ports; bound after the module. */
`timescale 1ns/10ps
module clg_clock_gen_properties (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic powerdown_bit_i,
    input wire logic idle_bit_i,
    input wire logic jtag_reset_toggle_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic core_clk_en_o,
    input wire logic watchdog_clk_en_o,
    input wire logic peripheral_clk_en_o,
    input wire logic debug_comparator_enable_o,
    input wire logic debug_core_ready_o,
    input wire logic low_power_exit_o
);
    logic lp;
    logic rhit;
    logic whit;
    assign lp = idle_bit_i | powerdown_bit_i;
    assign rhit = sfr_rd_i && sfr_addr_i == 8'hF9;
    assign whit = sfr_wr_i && sfr_addr_i == 8'hF9;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Two edges allow for a pulse already in flight
    sequence s_halted;
        lp [*2];
    endsequence
    a_core_halt: assert property (s_halted |=> !core_clk_en_o)
        else $error("core enable while halted");
    a_wdog_same: assert property (watchdog_clk_en_o == core_clk_en_o)
        else $error("watchdog enable differs");
    a_periph_idle: assert property (idle_bit_i && !powerdown_bit_i |=> peripheral_clk_en_o)
        else $error("peripheral stopped in idle");
    a_periph_pd: assert property (powerdown_bit_i |=> !peripheral_clk_en_o)
        else $error("peripheral runs in powerdown");
    a_ready_halt: assert property (lp |=> !debug_core_ready_o)
        else $error("core ready while halted");
    a_exit_cause: assert property (low_power_exit_o |->
        $past(lp) || $past(lp, 2) || $past(lp, 3))
        else $error("exit pulse in run mode");
    a_exit_pulse: assert property (low_power_exit_o |=> !low_power_exit_o)
        else $error("exit pulse too long");
    a_dbg_write: assert property (whit |=>
        debug_comparator_enable_o == $past(sfr_wdata_i[4]))
        else $error("enable bit not written");
    a_ready_run: assert property (!lp |=> debug_core_ready_o)
        else $error("core not ready in run mode");
    a_write_restart: assert property (whit |=> !core_clk_en_o)
        else $error("divider not restarted by write");
    a_read_dbg: assert property (rhit && !whit |=> sfr_rdata_o[4] == debug_comparator_enable_o
        && sfr_rdata_o[7:5] == 3'h0 && !sfr_rdata_o[3])
        else $error("read data wrong");
endmodule
bind clg_clock_gen clg_clock_gen_properties u_props (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .powerdown_bit_i(powerdown_bit_i),
    .idle_bit_i(idle_bit_i),
    .jtag_reset_toggle_i(jtag_reset_toggle_i),
    .sfr_rdata_o(sfr_rdata_o),
    .core_clk_en_o(core_clk_en_o),
    .watchdog_clk_en_o(watchdog_clk_en_o),
    .peripheral_clk_en_o(peripheral_clk_en_o),
    .debug_comparator_enable_o(debug_comparator_enable_o),
    .debug_core_ready_o(debug_core_ready_o),
    .low_power_exit_o(low_power_exit_o)
);

// file: testbench/clg_clock_gen_tb.sv
/* Self-checking bench for clg_clock_gen.
 Drives the register port and power bits directly; no partner model. */
`timescale 1ns/10ps
module clg_clock_gen_tb
    import clg_pkg::*;
;
    logic clk_i = 1'b0, reset_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    logic powerdown_bit_i = 1'b0, idle_bit_i = 1'b0, jtag_reset_toggle_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'hF9, sfr_wdata_i = 8'h00, sfr_rdata_o;
    logic core_clk_en_o, watchdog_clk_en_o, peripheral_clk_en_o;
    logic debug_comparator_enable_o, debug_core_ready_o, low_power_exit_o;
    int num_errors = 0, n_tests = 0, cyc = 0;
    logic [11:0] dv [8] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020,
        12'h400, 12'h800};
    clg_clock_gen u_dut (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i),
        .powerdown_bit_i(powerdown_bit_i),
        .idle_bit_i(idle_bit_i),
        .jtag_reset_toggle_i(jtag_reset_toggle_i),
        .sfr_rdata_o(sfr_rdata_o),
        .core_clk_en_o(core_clk_en_o),
        .watchdog_clk_en_o(watchdog_clk_en_o),
        .peripheral_clk_en_o(peripheral_clk_en_o),
        .debug_comparator_enable_o(debug_comparator_enable_o),
        .debug_core_ready_o(debug_core_ready_o),
        .low_power_exit_o(low_power_exit_o)
    );
    always #2 clk_i = ~clk_i;
    function automatic logic [11:0] b(input logic x);
        return {11'h000, x};
    endfunction
    task chk(input string nm, input logic [11:0] s, input logic [11:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task wr(input logic [7:0] d);
        tick(1);
        sfr_addr_i = 8'hF9;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        tick(1);
        sfr_rd_i = 1'b0;
        chk("rdata", {4'h0, sfr_rdata_o}, {4'h0, e});
    endtask
    // Steady spacing of core enable pulses
    task per(input logic [11:0] d);
        logic [11:0] n;
        n = 12'h000;
        while (core_clk_en_o !== 1'b1 && n < 12'hFFF) begin
            tick(1);
            n++;
        end
        n = 12'h000;
        do begin
            tick(1);
            n++;
        end while (core_clk_en_o !== 1'b1 && n < 12'hFFF);
        chk("period", n, d);
    endtask
    // Debug reset toggle; counts exit pulses so a doubled pulse shows
    task jt(input logic e, input logic c);
        logic [11:0] s;
        logic k;
        s = 12'h000;
        k = 1'b0;
        jtag_reset_toggle_i = ~jtag_reset_toggle_i;
        repeat (8) begin
            tick(1);
            s = s + b(low_power_exit_o);
            k |= core_clk_en_o;
        end
        chk("exit", s, b(e));
        chk("core", b(k), b(c));
    endtask
    task complete_run;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            complete_run;
        end
    end
    initial begin
        tick(5);
        reset_n_i = 1'b1;
        rd(8'hF9, 8'h10);
        per(12'h001);
        chk("dbg", b(debug_comparator_enable_o), 12'h001);
        for (int s = 0; s < 8; s++) begin
            wr({5'h02, s[2:0]});
            per(dv[s]);
            chk("periph", b(peripheral_clk_en_o), 12'h001);
        end
        wr(8'hEF);
        rd(8'hF9, 8'h07);
        chk("dbg", b(debug_comparator_enable_o), 12'h000);
        rd(8'hF8, 8'h00);
        wr(8'h11);
        idle_bit_i = 1'b1;
        tick(2);
        chk("periph", b(peripheral_clk_en_o), 12'h001);
        chk("ready", b(debug_core_ready_o), 12'h000);
        jt(1'b1, 1'b0);
        idle_bit_i = 1'b0;
        powerdown_bit_i = 1'b1;
        tick(2);
        chk("periph", b(peripheral_clk_en_o), 12'h000);
        jt(1'b1, 1'b0);
        powerdown_bit_i = 1'b0;
        tick(2);
        chk("periph", b(peripheral_clk_en_o), 12'h001);
        chk("ready", b(debug_core_ready_o), 12'h001);
        jt(1'b0, 1'b1);
        reset_n_i = 1'b0;
        tick(2);
        reset_n_i = 1'b1;
        // Toggle input is high here, so reset must not fake a command
        idle_bit_i = 1'b1;
        tick(1);
        jt(1'b1, 1'b0);
        rd(8'hF9, 8'h10);
        complete_run;
    end
endmodule
